/* inc/dcwd_pkg.sv */
// Package for the drive control word decoder: field positions, encodings and types.
package dcwd_pkg;

	localparam int unsigned CW_W            = 16;
	localparam int unsigned BIT_SWITCH_ON   = 0;
	localparam int unsigned BIT_VOLTAGE     = 1;
	localparam int unsigned BIT_QUICK_STOP  = 2;
	localparam int unsigned BIT_RUN_ENABLE  = 3;
	localparam int unsigned BIT_FAULT_ACK   = 7;
	localparam int unsigned BIT_HALT        = 8;
	localparam int unsigned BIT_DIRECTION   = 11;
	localparam logic [15:0] RESERVED_MASK   = 16'h0670;
	localparam logic [15:0] CW_RESET        = 16'h0000;

	// Assignment code: bits [7:6] kind, [5:4] fixed group or word, [3:0] bit index.
	localparam logic [1:0]  ASSIGN_NONE     = 2'h0;
	localparam logic [1:0]  ASSIGN_FIXED    = 2'h1;
	localparam logic [1:0]  ASSIGN_SWITCHED = 2'h2;
	// Fixed group 1 (this fieldbus word), bit 12.
	localparam logic [7:0]  fixed_word2_bit12_source = 8'h5c;
	localparam logic [1:0]  OWN_GROUP       = 2'h1;
	localparam logic [7:0]  ASSIGN_RESET    = 8'h00;

	// Function command assignments for the assignable bits.
	typedef struct packed {
		logic [7:0] fast_stop_assignment;
		logic [7:0] dc_brake_assignment;
		logic [7:0] coast_stop_assignment;
	} dcwd_assign_t;

	// Decoded commands toward the drive logic.
	typedef struct packed {
		logic switch_on;
		logic voltage_enable;
		logic quick_stop;
		logic run_enable;
		logic fault_ack;
		logic halt;
		logic reverse;
		logic fast_stop;
		logic dc_brake;
	} dcwd_cmd_t;

endpackage

/* design/dcwd_decoder.sv */
// Drive control word decoder for the state-machine motion profile.
`timescale 1ns/1ps
// Functional notes
// RULE1: Bits 0 to 3 decode as switch-on, voltage enable, quick stop and run enable.
// RULE2: The master writes zero to reserved bits 4, 5, 6, 9 and 10, which carry no command.
// RULE3: Bit 7 acknowledges a fault only on its rising edge, never on a level.
// RULE4: Bit 8 halts the motor with the configured stop while staying operation enabled.
// RULE5: By default bit 11 selects direction, forward at 0 and reverse at 1.
// RULE6: Assigning bit 11 to a function command removes its direction role.
// RULE7: Bits 12 to 15 have no default function and act only when assigned.
// RULE8: The fixed source for word 2 bit 12 makes that bit drive DC injection braking.
// RULE9: The assigned fast stop bit requests a stop when it is 1.
// RULE10: The assigned DC braking bit brakes when it is 1.
// RULE11: Fixed assignments act as priority stops even when the channel is inactive.
// RULE12: With fixed assignments the master holds both stop bits at 0 in order to start.
// RULE13: Switched assignments act only while this command channel is active.
// RULE14: A coast stop assigned to a control word bit is rejected in this profile.
// RULE15: Fault acknowledge compares each written word with the held one, one pulse per write.
module dcwd_decoder
	import dcwd_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         cw_write,
	input  wire logic [15:0]  cw_wdata,
	input  wire logic         channel_active,
	input  wire dcwd_assign_t assign_in,
	output logic [15:0]       cw_rdata,
	output dcwd_cmd_t         cmd,
	output logic              config_error
);

	logic [15:0]  cw_reg;
	logic [15:0]  cw_next;
	dcwd_assign_t asg_reg;
	dcwd_assign_t asg_next;
	dcwd_cmd_t    cmd_reg;
	dcwd_cmd_t    cmd_next;
	logic         err_reg;
	logic         err_next;
	logic         fast_hit;
	logic         dc_hit;

	// Tells whether an assignment code is a fixed one that lands on this word.
	function automatic logic is_fixed_own(input logic [7:0] code);
		return code[7:6] == ASSIGN_FIXED && code[5:4] == OWN_GROUP;
	endfunction

	// Tells whether an assignment code is a switched one, gated by the channel.
	function automatic logic is_switched(input logic [7:0] code);
		return code[7:6] == ASSIGN_SWITCHED;
	endfunction

	// Tells whether an assignment code picks a bit of this word and it is set.
	// A fixed code ignores the channel so that it can stop the drive from any source.
	function automatic logic assigned_bit(input logic [7:0] code, input logic [15:0] word,
		input logic active);
		logic hit;
		hit = 1'b0;
		if (is_fixed_own(code)) begin
			hit = word[code[3:0]];
		end else if (is_switched(code)) begin
			hit = word[code[3:0]] & active;
		end
		return hit;
	endfunction

	// Tells whether an assignment code lands on a given bit of this word.
	function automatic logic uses_bit(input logic [7:0] code, input logic [3:0] idx);
		return (is_switched(code) || is_fixed_own(code)) && code[3:0] == idx;
	endfunction

	// Accepts the configuration, refusing a coast stop tied to a control word bit.
	// The coast stop code is dropped so that it can never reach the drive logic.
	always_comb begin
		asg_next = asg_reg;
		err_next = err_reg;
		// RULE14: coast stop refused
		if (assign_in.coast_stop_assignment[7:6] != ASSIGN_NONE) begin
			err_next = 1'b1;
			asg_next.fast_stop_assignment = assign_in.fast_stop_assignment;
			asg_next.dc_brake_assignment  = assign_in.dc_brake_assignment;
			asg_next.coast_stop_assignment = ASSIGN_RESET;
		end else begin
			err_next = 1'b0;
			asg_next = assign_in;
		end
	end

	// Holds the written control word.
	always_comb begin
		cw_next = cw_reg;
		if (cw_write) begin
			cw_next = cw_wdata;
		end
	end

	// RULE9: fast stop active high
	// RULE11: fixed priority stop
	// RULE13: switched needs channel
	assign fast_hit = assigned_bit(asg_reg.fast_stop_assignment, cw_reg, channel_active);
	// RULE8: DC brake from bit
	// RULE10: brake active high
	assign dc_hit = assigned_bit(asg_reg.dc_brake_assignment, cw_reg, channel_active);

	// Decodes the held word into drive commands.
	// Only the fault acknowledge looks at the incoming word, to pulse once per write.
	always_comb begin
		cmd_next = '0;
		// RULE1: low four bits
		cmd_next.switch_on      = cw_reg[BIT_SWITCH_ON];
		cmd_next.voltage_enable = cw_reg[BIT_VOLTAGE];
		cmd_next.quick_stop     = cw_reg[BIT_QUICK_STOP];
		cmd_next.run_enable     = cw_reg[BIT_RUN_ENABLE];
		// RULE3: rising edge only
		// RULE15: compare with held word
		cmd_next.fault_ack = cw_write & cw_wdata[BIT_FAULT_ACK] & ~cw_reg[BIT_FAULT_ACK];
		// RULE4: halt keeps state
		cmd_next.halt = cw_reg[BIT_HALT];
		// RULE5: default direction bit
		// RULE6: assignment removes direction
		if (!uses_bit(asg_reg.fast_stop_assignment, 4'(BIT_DIRECTION)) &&
			!uses_bit(asg_reg.dc_brake_assignment, 4'(BIT_DIRECTION))) begin
			cmd_next.reverse = cw_reg[BIT_DIRECTION];
		end
		// RULE7: upper bits only assigned
		cmd_next.fast_stop = fast_hit;
		cmd_next.dc_brake  = dc_hit;
	end

	// Registers the configuration; the assignments clear to none on reset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			asg_reg <= {3{ASSIGN_RESET}};
			err_reg <= 1'b0;
		end else begin
			asg_reg <= asg_next;
			err_reg <= err_next;
		end
	end

	// Registers the held control word.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cw_reg <= CW_RESET;
		end else begin
			cw_reg <= cw_next;
		end
	end

	// Registers the decoded commands so that every output leaves a flip-flop.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_reg <= '0;
		end else begin
			cmd_reg <= cmd_next;
		end
	end

	assign cw_rdata     = cw_reg;
	assign cmd          = cmd_reg;
	assign config_error = err_reg;

	// A write whose fault acknowledge bit rises against the held word.
	sequence ack_rise_s;
		cw_write && cw_wdata[BIT_FAULT_ACK] && !cw_reg[BIT_FAULT_ACK];
	endsequence

	// A write and the cycle after it, in which the word is held.
	sequence word_held_s;
		cw_write ##1 1'b1;
	endsequence

	// RULE3: one pulse per edge
	fault_pulse_a: assert property (@(posedge clk) disable iff (rst)
		cmd.fault_ack |=> !cmd.fault_ack)
		else $error("fault acknowledge lasted more than one cycle");

	// RULE15: pulse follows write edge
	fault_cause_a: assert property (@(posedge clk) disable iff (rst)
		ack_rise_s |=> cmd.fault_ack)
		else $error("fault acknowledge missed after rising write");

	// RULE1: low bits follow word
	low_bits_a: assert property (@(posedge clk) disable iff (rst)
		word_held_s |=> (cmd.run_enable == $past(cw_wdata[BIT_RUN_ENABLE], 2)))
		else $error("run enable does not follow the written word");

	// RULE4: halt follows bit
	halt_bit_a: assert property (@(posedge clk) disable iff (rst)
		cmd.halt == $past(cw_reg[8]))
		else $error("halt does not follow bit 8");

	// RULE14: coast stop refused
	coast_refused_a: assert property (@(posedge clk) disable iff (rst)
		(assign_in.coast_stop_assignment[7:6] != 2'h0) |=> config_error)
		else $error("coast stop assignment was accepted");

	// RULE13: switched needs channel
	switched_gate_a: assert property (@(posedge clk) disable iff (rst)
		(asg_reg.fast_stop_assignment[7:6] == 2'h2 && !channel_active) |=> !cmd.fast_stop)
		else $error("switched fast stop acted on inactive channel");

	// RULE11: fixed ignores channel
	fixed_prio_a: assert property (@(posedge clk) disable iff (rst)
		(asg_reg.dc_brake_assignment == 8'h5c && cw_reg[12]) |=> cmd.dc_brake)
		else $error("fixed DC brake did not act");

	// RULE6: direction removed
	dir_removed_a: assert property (@(posedge clk) disable iff (rst)
		(asg_reg.fast_stop_assignment[7:6] == 2'h2 && asg_reg.fast_stop_assignment[3:0] == 4'hb)
		|=> !cmd.reverse)
		else $error("direction still active after reassignment");

	// Checks on the remaining decoded commands and on the held word.
	// RULE1: switch-on follows word
	switch_on_a: assert property (@(posedge clk) disable iff (rst)
		word_held_s |=> (cmd.switch_on == $past(cw_wdata[BIT_SWITCH_ON], 2)))
		else $error("switch-on does not follow the written word");

	// RULE1: voltage follows word
	voltage_bit_a: assert property (@(posedge clk) disable iff (rst)
		word_held_s |=> (cmd.voltage_enable == $past(cw_wdata[BIT_VOLTAGE], 2)))
		else $error("voltage enable does not follow the written word");

	// RULE1: quick stop follows
	quick_stop_a: assert property (@(posedge clk) disable iff (rst)
		word_held_s |=> (cmd.quick_stop == $past(cw_wdata[BIT_QUICK_STOP], 2)))
		else $error("quick stop does not follow the written word");

	// RULE15: word loads on write
	word_load_a: assert property (@(posedge clk) disable iff (rst)
		cw_write |=> (cw_rdata == $past(cw_wdata)))
		else $error("written word was not held");

	// RULE15: word holds without write
	word_hold_a: assert property (@(posedge clk) disable iff (rst)
		!cw_write |=> $stable(cw_rdata))
		else $error("held word changed without a write");

	// RULE3: steady level ignored
	fault_level_a: assert property (@(posedge clk) disable iff (rst)
		(cw_write && cw_wdata[BIT_FAULT_ACK] && cw_reg[BIT_FAULT_ACK]) |=> !cmd.fault_ack)
		else $error("fault acknowledge fired on a steady level");

	// RULE15: pulse needs a write
	fault_write_a: assert property (@(posedge clk) disable iff (rst)
		cmd.fault_ack |-> $past(cw_write))
		else $error("fault acknowledge without a write");

	// RULE4: halt keeps run enable
	halt_keep_a: assert property (@(posedge clk) disable iff (rst)
		cmd.halt |-> (cmd.run_enable == $past(cw_reg[BIT_RUN_ENABLE])))
		else $error("halt disturbed the run enable command");

	// RULE5: default direction bit
	reverse_default_a: assert property (@(posedge clk) disable iff (rst)
		(asg_reg.fast_stop_assignment[7:6] == ASSIGN_NONE &&
		asg_reg.dc_brake_assignment[7:6] == ASSIGN_NONE)
		|=> (cmd.reverse == $past(cw_reg[BIT_DIRECTION])))
		else $error("direction does not follow bit 11");

	// RULE7: upper bits idle
	upper_idle_a: assert property (@(posedge clk) disable iff (rst)
		(asg_reg.fast_stop_assignment[7:6] == ASSIGN_NONE &&
		asg_reg.dc_brake_assignment[7:6] == ASSIGN_NONE)
		|=> (!cmd.fast_stop && !cmd.dc_brake))
		else $error("unassigned bit raised a function command");

	// RULE8: bit 12 drives braking
	brake_source_a: assert property (@(posedge clk) disable iff (rst)
		(asg_reg.dc_brake_assignment == fixed_word2_bit12_source)
		|=> (cmd.dc_brake == $past(cw_reg[12])))
		else $error("DC braking does not follow bit 12");

	// RULE9: fast stop active high
	fast_level_a: assert property (@(posedge clk) disable iff (rst)
		is_fixed_own(asg_reg.fast_stop_assignment)
		|=> (cmd.fast_stop == $past(cw_reg[asg_reg.fast_stop_assignment[3:0]])))
		else $error("fixed fast stop does not follow its bit");

	// RULE10: braking active high
	brake_level_a: assert property (@(posedge clk) disable iff (rst)
		is_fixed_own(asg_reg.dc_brake_assignment)
		|=> (cmd.dc_brake == $past(cw_reg[asg_reg.dc_brake_assignment[3:0]])))
		else $error("fixed DC braking does not follow its bit");

	// RULE11: fixed fast stop priority
	fast_prio_a: assert property (@(posedge clk) disable iff (rst)
		(is_fixed_own(asg_reg.fast_stop_assignment) && !channel_active &&
		cw_reg[asg_reg.fast_stop_assignment[3:0]]) |=> cmd.fast_stop)
		else $error("fixed fast stop did not act on inactive channel");

	// RULE13: switched follows when active
	fast_switched_a: assert property (@(posedge clk) disable iff (rst)
		(is_switched(asg_reg.fast_stop_assignment) && channel_active)
		|=> (cmd.fast_stop == $past(cw_reg[asg_reg.fast_stop_assignment[3:0]])))
		else $error("switched fast stop ignored its bit on active channel");

	// RULE13: switched braking gated
	brake_gate_a: assert property (@(posedge clk) disable iff (rst)
		(is_switched(asg_reg.dc_brake_assignment) && !channel_active) |=> !cmd.dc_brake)
		else $error("switched DC braking acted on inactive channel");

	// RULE14: config error clears
	coast_clear_a: assert property (@(posedge clk) disable iff (rst)
		(assign_in.coast_stop_assignment[7:6] == ASSIGN_NONE) |=> !config_error)
		else $error("config error stayed without a coast stop assignment");

endmodule // dcwd_decoder

/* verif/dcwd_master_model.sv */
// Behavioural fieldbus master that writes the drive control word.
`timescale 1ns/1ps
module dcwd_master_model
	import dcwd_pkg::*;
(
	input  wire logic   clk,
	output logic        cw_write,
	output logic [15:0] cw_wdata
);
	// Sends one word with a one-cycle strobe, changed at the falling edge.
	task automatic send(input logic [15:0] word);
		@(negedge clk);
		cw_wdata = word & ~RESERVED_MASK;
		cw_write = 1'b1;
		@(negedge clk);
		cw_write = 1'b0;
		cw_wdata = ~cw_wdata; // Data means nothing without the strobe.
	endtask

	// Idle state at time zero.
	initial begin
		cw_write = 1'b0;
		cw_wdata = 16'h0000;
	end
endmodule // dcwd_master_model

/* verif/tb.sv */
// Testbench for the drive control word decoder.
`timescale 1ns/1ps
module tb import dcwd_pkg::*;;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         cw_write;
	logic [15:0]  cw_wdata;
	logic         channel_active = 1'b0;
	dcwd_assign_t assign_in = 24'h000000;
	logic [15:0]  cw_rdata;
	dcwd_cmd_t    cmd;
	logic         config_error;
	logic         ack_seen;
	int           err_total = 0;
	int           compares = 0;

	// Clock of 5 ns period.
	always #2.5 clk = ~clk;

	dcwd_master_model u_master (.clk(clk), .cw_write(cw_write), .cw_wdata(cw_wdata));

	dcwd_decoder u_dut (.clk(clk), .rst(rst), .cw_write(cw_write), .cw_wdata(cw_wdata),
		.channel_active(channel_active), .assign_in(assign_in), .cw_rdata(cw_rdata),
		.cmd(cmd), .config_error(config_error));

	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (err_total == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Writes a word, catches the acknowledge pulse, then checks the levels.
	task automatic wr(input logic [15:0] w, input logic [8:0] exp, input logic ack);
		u_master.send(w);
		ack_seen = cmd.fault_ack;
		chk({15'h0000, ack_seen}, {15'h0000, ack});
		@(negedge clk);
		chk(cw_rdata, w);
		chk({7'h00, cmd}, {7'h00, exp});
	endtask

	// Cuts a hang short.
	initial begin
		#100000;
		err_total++;
		stop_test();
	end

	// Main sequence.
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		chk({6'h00, config_error, cmd}, 16'h0000);
		wr(16'h000f, 9'h1e0, 1'b0);
		wr(16'h0880, 9'h004, 1'b1);
		wr(16'h0880, 9'h004, 1'b0);
		wr(16'h0100, 9'h008, 1'b0);
		wr(16'h1000, 9'h000, 1'b0);
		assign_in = 24'h005c00;
		repeat (3) @(negedge clk);
		wr(16'h1000, 9'h001, 1'b0);
		wr(16'h0000, 9'h000, 1'b0);
		assign_in = 24'h5d0000;
		repeat (3) @(negedge clk);
		wr(16'h2000, 9'h002, 1'b0);
		wr(16'h0000, 9'h000, 1'b0);
		assign_in = 24'h8b0000;
		channel_active = 1'b1;
		repeat (3) @(negedge clk);
		wr(16'h0800, 9'h002, 1'b0);
		channel_active = 1'b0;
		repeat (3) @(negedge clk);
		chk({7'h00, cmd}, 16'h0000);
		assign_in = 24'h00008c;
		repeat (3) @(negedge clk);
		chk({15'h0000, config_error}, 16'h0001);
		assign_in = 24'h000000;
		repeat (3) @(negedge clk);
		chk({15'h0000, config_error}, 16'h0000);
		stop_test();
	end
endmodule // tb
